/* include/rmd_pkg.sv */
// package: constants and carriers for the receive mac datapath
package rmd_pkg;
  // ----------------------------------------------------------------
  // lane geometry
  // ----------------------------------------------------------------
  localparam int LANES = 8; // byte lanes per word, lane 0 is the msb
  localparam int DW = 64; // data bits per word
  localparam logic [3:0] FULL_NB = 4'h8; // byte count of a full word
  localparam logic [3:0] CRC_BYTES = 4'h4; // check field length
  // ----------------------------------------------------------------
  // phy control characters and preamble
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_START = 8'hFB;
  localparam logic [7:0] CH_TERM = 8'hFD;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [63:0] START_WORD = {CH_START, {6{PRE_BYTE}}, SFD_BYTE};
  localparam logic [7:0] START_CTRL = 8'h80; // only lane 0 is control
  // ----------------------------------------------------------------
  // crc-32, reflected form, residue over data plus check field
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  // ----------------------------------------------------------------
  // control frame identification
  // ----------------------------------------------------------------
  localparam logic [15:0] ETYPE_CTRL = 16'h8808;
  localparam logic [15:0] OPC_PAUSE = 16'h0001;
  localparam logic [15:0] OPC_PFC = 16'h0101;
  localparam logic [2:0] CLS_NONE = 3'h0;
  localparam logic [2:0] CLS_STD = 3'h1;
  localparam logic [2:0] CLS_PFC = 3'h2;
  localparam logic [2:0] CLS_OTHER = 3'h4;
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_STD = 2'h1;
  localparam logic [1:0] FLOW_PFC = 2'h2;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CRC_CFG = 8'h00; // crc_strip_config_reg
  localparam logic [7:0] ADDR_PAUSE_FWD = 8'h04;
  localparam logic [7:0] ADDR_PAUSE_EN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_FCS_CNT = 8'h10;
  localparam logic CRC_STRIP_RST = 1'b1;
  localparam logic PAUSE_FWD_RST = 1'b0;
  localparam logic [7:0] PAUSE_EN_RST = 8'hFF;
  localparam int ERR_MALFORMED = 0; // error vector bit positions
  localparam int ERR_FCS = 1;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0] data; // lane 0 in [63:56]
    logic [7:0] ctrl; // bit 7 flags lane 0 as control
  } rmd_phy_word_type;
  typedef struct packed {
    logic [63:0] data;
    logic [3:0] nb; // valid bytes, zero for an empty stage
    logic sop;
    logic last;
    logic pkt; // packet word, clear for forwarded gap
    logic [1:0] err;
  } rmd_stage_type;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [2:0] empty;
    logic [63:0] data;
    logic [1:0] err;
    logic fcs_error;
    logic fcs_valid;
    logic [2:0] ctrl_flag;
  } rmd_client_type;
endpackage

/* logic/rmd_rx_mac.sv */
// module: receive mac datapath from phy lanes to packet client stream
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
//
// Overview of operation
// - drop pause frames by default
// - forward pause frames when forward bit set
// - check start, six preamble bytes, delimiter
// - accept start only on lane zero
// - delimiter 0xD5 ends the preamble
// - strip preamble unless passthrough built in
// - crc strip bit 0, enabled at reset
// - eop on last crc or payload byte
// - fcs error, fcs valid, error bit 1 together
// - fcs error with eop or one cycle later
// - check field arrives highest term first
// - terminate character produces end of packet
// - error character ends packet as malformed
// - other control character ends packet malformed
// - inserted link errors flagged as malformed
// - drop gap octets unless custom interface
// - act on pause only when enabled
// - mismatched control frames pass through unchanged
// - one-hot control flag with every control packet, zero for other packets
// - empty count of unused low lanes
// - first packet byte on msb lane
module rmd_rx_mac import rmd_pkg::*; #(
  parameter bit PREAMBLE_PASS = 1'b0, // keep the eight-byte preamble
  parameter bit EOP_ALIGN_FCS = 1'b1, // fcs status in the eop cycle
  parameter bit CUSTOM_IF = 1'b0, // forward gap octets to client
  parameter logic [1:0] FLOW_MODE = FLOW_STD
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire rmd_phy_word_type i_phy,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output rmd_client_type o_rx,
  output logic o_pause_rcvd
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte of lane i, lane 0 being the most significant
  function automatic logic [7:0] lane_byte(input logic [63:0] w,
                                           input int i);
    lane_byte = w[DW-1-8*i -: 8];
  endfunction
  // one byte into the reflected crc, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction
  // the first nb lanes of a word into the crc
  function automatic logic [31:0] crc_word(input logic [31:0] c,
                                           input logic [63:0] w,
                                           input logic [3:0] nb);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < LANES; i++) begin
      if (i < int'(nb)) begin
        r = crc_byte(r, lane_byte(w, i));
      end
    end
    crc_word = r;
  endfunction
  // type and opcode sit in bytes 4..7 of the second data word
  function automatic logic [2:0] classify(input logic [63:0] w2);
    if (w2[31:16] != ETYPE_CTRL) begin
      classify = CLS_NONE;
    end else if (w2[15:0] == OPC_PAUSE) begin
      classify = CLS_STD;
    end else if (w2[15:0] == OPC_PFC) begin
      classify = CLS_PFC;
    end else begin
      classify = CLS_OTHER;
    end
  endfunction
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } rmd_state_type;
  localparam logic [2:0] CLS_MATCH = (FLOW_MODE == FLOW_STD) ? CLS_STD :
                                     (FLOW_MODE == FLOW_PFC) ? CLS_PFC :
                                     CLS_NONE;
  rmd_state_type st; // frame receive state
  rmd_state_type next_st;
  rmd_stage_type s0; // newest pipeline stage
  rmd_stage_type s1; // stage feeding the client output
  rmd_stage_type next_s0;
  rmd_stage_type next_s1;
  logic [31:0] crc_q; // running crc of the frame
  logic [1:0] wcnt; // data words seen, saturates at 2
  logic cls_set; // frame class known
  logic [2:0] cls_q; // latched frame class
  logic crc_strip; // crc_strip_config_reg bit 0
  logic pause_fwd; // forward matching pause frames
  logic [7:0] pause_en; // pause receive enables
  logic [31:0] fcs_cnt; // frames ended with an fcs error
  logic fcs_dly_v; // delayed fcs report, unaligned build
  logic [1:0] fcs_dly_err;
  // ----------------------------------------------------------------
  // phy word decode
  // ----------------------------------------------------------------
  wire logic start_ok = (i_phy.ctrl == START_CTRL) &&
                        (i_phy.data == START_WORD);
  wire logic data_word = (i_phy.ctrl == 8'h00);
  wire logic in_frame = (st == ST_FRAME);
  wire logic tail_now = in_frame && !data_word;
  logic [3:0] t_lane; // first control lane of the word
  always_comb begin
    t_lane = 4'h0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (i_phy.ctrl[LANES-1-i]) begin
        t_lane = 4'(i);
      end
    end
  end
  // anything but terminate (error, idle, start) ends the frame badly
  wire logic malformed = lane_byte(i_phy.data, int'(t_lane)) != CH_TERM;
  wire logic [31:0] crc_end = crc_word(crc_q, i_phy.data, t_lane);
  wire logic fcs_bad = malformed || (crc_end != CRC_RESIDUE);
  wire logic [1:0] end_err = {fcs_bad, malformed};
  // ----------------------------------------------------------------
  // tail trimming: the check field may straddle two words
  // ----------------------------------------------------------------
  wire logic [3:0] cut = crc_strip ? CRC_BYTES : 4'h0;
  wire logic s0_cur = s0.pkt && (s0.nb != 4'h0) && !s0.last;
  wire logic cut_in_part = (t_lane >= cut);
  wire logic [3:0] part_raw = cut_in_part ? t_lane - cut : 4'h0;
  wire logic [3:0] s0_nb_end = cut_in_part ? FULL_NB :
                               4'(FULL_NB - (cut - t_lane));
  // a frame with no earlier word still closes with one byte
  wire logic part_v = (part_raw != 4'h0) || !s0_cur;
  wire logic [3:0] part_nb = (part_raw != 4'h0) ? part_raw : 4'h1;
  // ----------------------------------------------------------------
  // frame class and drop decision
  // ----------------------------------------------------------------
  wire logic cls_at_in = in_frame && data_word && (wcnt == 2'h1);
  wire logic [2:0] cls_eff = cls_set ? cls_q :
                             cls_at_in ? classify(i_phy.data) : CLS_NONE;
  // only frames of the built flow mode are ours to swallow
  wire logic drop_eff = (CLS_MATCH != CLS_NONE) && (cls_eff == CLS_MATCH)
                        && !pause_fwd;
  wire logic s1_v = (s1.nb != 4'h0);
  wire logic s1_end = s1_v && s1.last;
  wire logic out_v = s1_v && !(s1.pkt && drop_eff);
  wire logic en_any = (FLOW_MODE == FLOW_STD) ? pause_en[0] :
                      (FLOW_MODE == FLOW_PFC) ? (|pause_en) : 1'b0;
  // ----------------------------------------------------------------
  // next stage values
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_s0 = '0;
    next_s1 = s0;
    case (st)
      ST_IDLE: begin
        if (start_ok) begin
          next_st = ST_FRAME;
          if (PREAMBLE_PASS) begin
            next_s0 = '{START_WORD, FULL_NB, 1'b1, 1'b0, 1'b1, 2'b00};
          end
        end else if (CUSTOM_IF) begin
          next_s0 = '{i_phy.data, FULL_NB, 1'b0, 1'b0, 1'b0, 2'b00};
        end
      end
      ST_FRAME: begin
        if (!tail_now) begin // no control lane yet, frame goes on
          // sop lands on the msb lane of the first word
          next_s0 = '{i_phy.data, FULL_NB,
                      (wcnt == 2'h0) && !PREAMBLE_PASS,
                      1'b0, 1'b1, 2'b00};
        end else begin
          next_st = ST_IDLE; // a later terminate gets no eop
          if (part_v) begin
            next_s0 = '{i_phy.data, part_nb, (wcnt == 2'h0) &&
                        !PREAMBLE_PASS && !s0_cur, 1'b1, 1'b1, end_err};
          end
          if (s0_cur) begin
            next_s1.nb = s0_nb_end;
            next_s1.last = !part_v;
            next_s1.err = part_v ? 2'b00 : end_err;
          end
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // receive pipeline, shifts every cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= ST_IDLE;
      s0 <= '0;
      s1 <= '0;
    end else begin
      st <= next_st;
      s0 <= next_s0;
      s1 <= next_s1;
    end
  end
  // crc and word count; check field bits fold in lsb first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crc_q <= CRC_INIT;
      wcnt <= 2'h0;
    end else if (!in_frame) begin
      crc_q <= CRC_INIT;
      wcnt <= 2'h0;
    end else if (data_word) begin
      crc_q <= crc_word(crc_q, i_phy.data, FULL_NB);
      wcnt <= (wcnt == 2'h2) ? wcnt : wcnt + 2'h1;
    end
  end
  // class holds until the frame's last word leaves the pipe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cls_set <= 1'b0;
      cls_q <= CLS_NONE;
    end else if (cls_at_in) begin
      cls_set <= 1'b1;
      cls_q <= classify(i_phy.data);
    end else if (s1_end) begin
      cls_set <= 1'b0;
      cls_q <= CLS_NONE;
    end
  end
  // ----------------------------------------------------------------
  // client output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx <= '0;
      fcs_dly_v <= 1'b0;
      fcs_dly_err <= 2'b00;
    end else begin
      o_rx.valid <= out_v;
      o_rx.sop <= out_v && s1.sop;
      o_rx.eop <= out_v && s1.last;
      o_rx.empty <= 3'(FULL_NB - s1.nb);
      o_rx.data <= s1.data;
      o_rx.ctrl_flag <= (out_v && s1.pkt) ? cls_eff : CLS_NONE;
      fcs_dly_v <= out_v && s1.last;
      fcs_dly_err <= s1.err;
      if (EOP_ALIGN_FCS) begin
        o_rx.fcs_valid <= out_v && s1.last;
        o_rx.fcs_error <= out_v && s1.last && s1.err[ERR_FCS];
        o_rx.err <= (out_v && s1.last) ? s1.err : 2'b00;
      end else begin
        o_rx.fcs_valid <= fcs_dly_v;
        o_rx.fcs_error <= fcs_dly_v && fcs_dly_err[ERR_FCS];
        o_rx.err <= fcs_dly_v ? fcs_dly_err : 2'b00;
      end
    end
  end
  // good pause frame of the built mode reaches the pause logic
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pause_rcvd <= 1'b0;
    end else begin
      o_pause_rcvd <= s1_end && (cls_eff == CLS_MATCH) &&
                      (CLS_MATCH != CLS_NONE) && en_any &&
                      (s1.err == 2'b00);
    end
  end
  // ----------------------------------------------------------------
  // apb slave: one wait state, then pready for one cycle
  // ----------------------------------------------------------------
  wire logic apb_acc = i_psel && i_penable;
  wire logic apb_first = apb_acc && !o_pready;
  wire logic wr_fire = apb_acc && o_pready && i_pwrite;
  wire logic addr_hit = (i_paddr == ADDR_CRC_CFG) ||
                        (i_paddr == ADDR_PAUSE_FWD) ||
                        (i_paddr == ADDR_PAUSE_EN) ||
                        (i_paddr == ADDR_STATUS) ||
                        (i_paddr == ADDR_FCS_CNT);
  logic [31:0] rd_mux;
  always_comb begin
    case (i_paddr)
      ADDR_CRC_CFG: rd_mux = {31'h0, crc_strip};
      ADDR_PAUSE_FWD: rd_mux = {31'h0, pause_fwd};
      ADDR_PAUSE_EN: rd_mux = {24'h0, pause_en};
      ADDR_STATUS: rd_mux = {29'h0, cls_set, s0_cur, in_frame};
      ADDR_FCS_CNT: rd_mux = fcs_cnt;
      default: rd_mux = 32'h0;
    endcase
  end
  // answer registers; unmapped addresses answer with pslverr
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_first;
      o_prdata <= (apb_first && !i_pwrite) ? rd_mux : 32'h0;
      o_pslverr <= apb_first && !addr_hit;
    end
  end
  // configuration writes take effect at the completing edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crc_strip <= CRC_STRIP_RST;
      pause_fwd <= PAUSE_FWD_RST;
      pause_en <= PAUSE_EN_RST;
    end else if (wr_fire) begin
      if (i_paddr == ADDR_CRC_CFG) begin
        crc_strip <= i_pwdata[0];
      end
      if (i_paddr == ADDR_PAUSE_FWD) begin
        pause_fwd <= i_pwdata[0];
      end
      if (i_paddr == ADDR_PAUSE_EN) begin
        pause_en <= i_pwdata[7:0];
      end
    end
  end
  // counter wraps; no clear, software takes differences
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fcs_cnt <= 32'h0;
    end else if (s1_end && s1.err[ERR_FCS]) begin
      fcs_cnt <= fcs_cnt + 32'h1;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic pkt_open; // helper: client packet between sop and eop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pkt_open <= 1'b0;
    end else if (o_rx.valid && o_rx.eop) begin
      pkt_open <= 1'b0;
    end else if (o_rx.valid && o_rx.sop) begin
      pkt_open <= 1'b1;
    end
  end
  property p_start_seq;
    $rose(in_frame) |-> $past(i_phy.data) == START_WORD &&
                        $past(i_phy.ctrl) == START_CTRL;
  endproperty
  a_start_seq: assert property (p_start_seq)
    else $error("frame accepted without valid preamble");
  property p_fcs_trio;
    o_rx.fcs_error |-> o_rx.fcs_valid && o_rx.err[ERR_FCS];
  endproperty
  a_fcs_trio: assert property (p_fcs_trio)
    else $error("fcs error without valid or error bit");
  property p_fcs_align;
    o_rx.valid && o_rx.eop |-> if (EOP_ALIGN_FCS) o_rx.fcs_valid
                               else ##1 o_rx.fcs_valid;
  endproperty
  a_fcs_align: assert property (p_fcs_align)
    else $error("fcs report at wrong cycle against eop");
  property p_pause_drop;
    o_rx.valid |-> !(CLS_MATCH != CLS_NONE && !pause_fwd &&
                     o_rx.ctrl_flag == CLS_MATCH);
  endproperty
  a_pause_drop: assert property (p_pause_drop)
    else $error("pause frame reached client while not forwarded");
  property p_malformed;
    o_rx.err[ERR_MALFORMED] |-> o_rx.fcs_error;
  endproperty
  a_malformed: assert property (p_malformed)
    else $error("malformed packet without fcs error");
  property p_one_eop;
    o_rx.valid && o_rx.eop |-> pkt_open || o_rx.sop;
  endproperty
  a_one_eop: assert property (p_one_eop)
    else $error("eop without an open packet");
  property p_empty;
    o_rx.valid && !o_rx.eop |-> o_rx.empty == 3'h0;
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty lanes reported before eop");
  property p_no_gap;
    o_rx.valid && !CUSTOM_IF |-> pkt_open || o_rx.sop;
  endproperty
  a_no_gap: assert property (p_no_gap)
    else $error("gap octets forwarded to packet client");
  property p_strip_cfg;
    $changed(crc_strip) |-> $past(wr_fire) &&
                            $past(i_paddr) == ADDR_CRC_CFG;
  endproperty
  a_strip_cfg: assert property (p_strip_cfg)
    else $error("crc strip bit changed without a write");
  property p_pause_act;
    o_pause_rcvd |-> $past(en_any) && $past(s1_end, 1);
  endproperty
  a_pause_act: assert property (p_pause_act)
    else $error("pause acted on while disabled");
  c_fcs_bad: cover property (o_rx.fcs_error && o_rx.valid);
  c_malformed: cover property (o_rx.err[ERR_MALFORMED]);
  c_pause_fwd: cover property (o_rx.valid && o_rx.ctrl_flag != CLS_NONE);
endmodule

/* dv/rmd_client_sink.sv */
// client sink model: collects the receive stream for the bench
`timescale 1ns/1ps
module rmd_client_sink import rmd_pkg::*; (
  input wire logic i_clk,
  input wire rmd_client_type i_rx,
  input wire logic i_pause
);
  logic [63:0] got[$]; // packet words in arrival order
  rmd_client_type first = '0; // status of the first word
  rmd_client_type last_eop = '0; // status seen with end of packet
  int pauses = 0; // pause indications seen
  // always ready: the stream has no back pressure to apply
  always @(posedge i_clk) begin
    if (i_rx.valid === 1'b1) begin
      if (got.size() == 0) begin
        first = i_rx;
      end
      got.push_back(i_rx.data);
      if (i_rx.eop === 1'b1) begin
        last_eop = i_rx;
      end
    end
    if (i_pause === 1'b1) begin
      pauses++;
    end
  end
  // forget everything before the next frame
  function automatic void clear();
    got.delete();
    first = '0;
    last_eop = '0;
    pauses = 0;
  endfunction
endmodule

/* dv/rmd_rx_mac_bench.sv */
// self-checking bench for the receive mac datapath
`timescale 1ns/1ps
module rmd_rx_mac_bench import rmd_pkg::*;;
  // ------------------------------------------------------------
  // stimulus and observation signals
  // ------------------------------------------------------------
  localparam logic [63:0] IDLE = 64'h0707070707070707;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, perr, rerr, pause;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, fcs;
  rmd_phy_word_type phy = '{IDLE, 8'hFF};
  rmd_client_type rx;
  int mismatches = 0, checks_done = 0, cycles = 0, seed = 17;
  logic [63:0] w[$], ex[$];
  rmd_rx_mac DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_phy(phy),
    .i_paddr(paddr), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(perr), .o_rx(rx), .o_pause_rcvd(pause));
  rmd_client_sink sink (.i_clk(i_clk), .i_rx(rx), .i_pause(pause));
  always #5 i_clk = ~i_clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0);
    chk(64'({rerr, rd}), 64'(e));
  endtask
  // reflected crc-32, lane 0 byte first
  function automatic logic [31:0] crc_of(input logic [63:0] q[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        c = c ^ {24'h0, q[i][8*k +: 8]};
        for (int j = 0; j < 8; j++) begin
          c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
      end
    end
    return ~c;
  endfunction
  task automatic fill(input int n);
    w.delete();
    repeat (n) w.push_back({$random(seed), $random(seed)});
  endtask
  // start word, data words, check field then end character at lane 4
  task automatic send(input logic [63:0] st, input logic [7:0] sc,
    input logic [7:0] tc, input logic bad);
    fcs = crc_of(w) ^ {31'h0, bad};
    @(posedge i_clk);
    phy <= '{st, sc};
    foreach (w[i]) begin
      @(posedge i_clk);
      phy <= '{w[i], 8'h00};
    end
    @(posedge i_clk);
    phy <= '{{fcs[7:0], fcs[15:8], fcs[23:16], fcs[31:24], tc,
      24'h070707}, 8'h0F};
    @(posedge i_clk);
    phy <= '{IDLE, 8'hFF};
    repeat (6) @(posedge i_clk);
  endtask
  task automatic expect_pkt(input logic strip, input logic [1:0] er,
    input logic [2:0] fl);
    logic [63:0] m;
    ex = w;
    if (!strip) begin
      ex.push_back({fcs[7:0], fcs[15:8], fcs[23:16], fcs[31:24], 32'h0});
    end
    chk(64'(sink.got.size()), 64'(ex.size()));
    foreach (ex[i]) begin
      m = (!strip && i == ex.size() - 1) ? 64'hFFFFFFFF00000000 : '1;
      chk(sink.got[i] & m, ex[i]);
    end
    chk(64'(sink.first.sop), 64'h1);
    chk(64'({sink.last_eop.empty, sink.last_eop.err,
      sink.last_eop.fcs_error, sink.last_eop.fcs_valid,
      sink.last_eop.ctrl_flag}), 64'({strip ? 3'h0 : 3'h4, er, er[1],
      1'b1, fl}));
    sink.clear();
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] ops[3];
    ops = '{OPC_PAUSE, OPC_PFC, 16'h0002};
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdchk(ADDR_CRC_CFG, 33'h1);
    rdchk(ADDR_PAUSE_FWD, 33'h0);
    rdchk(ADDR_PAUSE_EN, 33'hFF);
    rdchk(8'h20, 33'h100000000);
    for (int i = 0; i < 5; i++) begin
      fill(2 + ($random(seed) & 3));
      send(START_WORD, 8'h80, CH_TERM, 1'b0);
      expect_pkt(1'b1, 2'b00, CLS_NONE);
    end
    send(START_WORD, 8'h80, CH_TERM, 1'b1);
    expect_pkt(1'b1, 2'b10, CLS_NONE);
    send(START_WORD, 8'h80, 8'hFE, 1'b0);
    expect_pkt(1'b1, 2'b11, CLS_NONE);
    send(START_WORD, 8'h80, 8'h07, 1'b0);
    expect_pkt(1'b1, 2'b11, CLS_NONE);
    rdchk(ADDR_FCS_CNT, 33'h3);
    apb(1'b1, ADDR_CRC_CFG, 32'h0);
    send(START_WORD, 8'h80, CH_TERM, 1'b0);
    expect_pkt(1'b0, 2'b00, CLS_NONE);
    apb(1'b1, ADDR_CRC_CFG, 32'h1);
    send(START_WORD ^ 64'h0000100000000000, 8'h80, CH_TERM, 1'b0);
    send({24'h070707, START_WORD[63:24]}, 8'hF0, CH_TERM, 1'b0);
    chk(64'(sink.got.size()), 64'h0);
    fill(3);
    w[1] = {w[1][63:32], ETYPE_CTRL, OPC_PAUSE};
    send(START_WORD, 8'h80, CH_TERM, 1'b0);
    chk(64'({sink.got.size(), sink.pauses}), 64'h1);
    sink.clear();
    apb(1'b1, ADDR_PAUSE_EN, 32'h0);
    send(START_WORD, 8'h80, CH_TERM, 1'b0);
    chk(64'({sink.got.size(), sink.pauses}), 64'h0);
    sink.clear();
    w[1] = {w[1][63:32], ETYPE_CTRL, OPC_PFC};
    send(START_WORD, 8'h80, CH_TERM, 1'b0);
    expect_pkt(1'b1, 2'b00, CLS_PFC);
    apb(1'b1, ADDR_PAUSE_EN, 32'hFF);
    apb(1'b1, ADDR_PAUSE_FWD, 32'h1);
    for (int i = 0; i < 3; i++) begin
      w[1] = {w[1][63:32], ETYPE_CTRL, ops[i]};
      send(START_WORD, 8'h80, CH_TERM, 1'b0);
      expect_pkt(1'b1, 2'b00, 3'(1 << i));
    end
    end_of_test();
  end
endmodule
